// ### rtl/mem_defs.svh
// Purpose: constants of the motion event manager
// Assumes: one 16-bit register per aligned word, byte address = 4 * index
// Notes: included by the top module and the testbench
// What this block does
// - each timer has a 16-bit up/down counter and a 16-bit control register
// - timer compare and period registers are shadowed and loaded later
// - timer clock is internal or external, both through a prescaler
// - each timer flags underflow, overflow, compare and period, each maskable
// - directional mode counts up or down by the direction pin level
// - two continuous modes and one directional mode; timers run alone or synchronized
// - timer 1 drives compares; capture uses timer 1 or 2; encoder uses timer 2
// - three compare units make six outputs, each with its own active state
// - compare unit values are shadowed so widths change while running
// - deadband uses three 4-bit counters and a 16-bit value register
// - deadband is enabled separately for each compare unit
// - each compare signal gives a complementary pair set by shadowed action bits
// - up to eight pulse outputs: three pairs plus two timer outputs
// - asymmetric, symmetric and space-vector patterns are available
// - qualified low protect input floats all pulse pins while its mask bit (IMRA bit 0) is set; level read at bit 8
// - extension control bits are all off after reset
// - three captures push the chosen timer count into two-deep stacks
// - capture levels must stay stable for two clock edges to count
// - capture edge is rising, falling or both, per channel
// - each capture channel has its own maskable flag
// - encoder mode counts timer 2 on every edge of both phases
// - converter start trigger drives the pin shared with the timer trip input
// - protect flag is set two cycles late, masked or not
// - undefined registers read zero and ignore writes; unused bits read zero only in the extension, mask, flag and stack status registers
`ifndef MEM_DEFS_SVH
`define MEM_DEFS_SVH
`define MEM_R_GPT 6'h00
`define MEM_R_T1 6'h01
`define MEM_R_T2 6'h05
`define MEM_O_CNT 6'h00
`define MEM_O_CMP 6'h01
`define MEM_O_PER 6'h02
`define MEM_O_CON 6'h03
`define MEM_R_EXT 6'h09
`define MEM_R_COMCON 6'h11
`define MEM_R_ACT 6'h13
`define MEM_R_DB 6'h15
`define MEM_R_CMP1 6'h17
`define MEM_R_CAPCON 6'h20
`define MEM_R_CAPST 6'h22
`define MEM_R_CAPTOP 6'h23
`define MEM_R_CAPBOT 6'h27
`define MEM_R_IMRA 6'h2c
`define MEM_R_IMRB 6'h2d
`define MEM_R_IMRC 6'h2e
`define MEM_R_IFRA 6'h2f
`define MEM_R_IFRB 6'h30
`define MEM_R_IFRC 6'h31
`define MEM_F_PDP 8
`define MEM_F_SVM 12
`define MEM_F_SVDIR 15
`define MEM_F_CEN 15
`define MEM_F_DBEN 13
`define MEM_F_DBV 8
`define MEM_F_ENC 12
`define MEM_F_CTB 3
`define MEM_F_CEDGE 6
`define MEM_F_SOCEN 0
`define MEM_F_TRIPEN 1
`define MEM_RST_IMRA 16'h0001
`define MEM_RST_WORD 16'h0000
`define MEM_SOC_UND 2'h1
`define MEM_SOC_PER 2'h2
`define MEM_SOC_CMP 2'h3
`define MEM_ENC_UP 2'h1
`define MEM_ENC_DN 2'h3
`endif

// ### rtl/mem_pkg.sv
// Purpose: types of the motion event manager
// Assumes: constants come from mem_defs.svh
// Notes: timer control word layout is carried as a packed struct
package mem_pkg;
  typedef enum logic [1:0] {MEM_HOLD, MEM_CONT_UP, MEM_CONT_UPDN, MEM_DIR_UPDN} mem_tmode_e;
  typedef struct packed {
    logic [5:0] spare;
    logic pol;
    logic oe;
    logic sync;
    logic en;
    logic ext;
    logic [2:0] pre;
    mem_tmode_e mode;
  } mem_tcon_s;
endpackage

// ### rtl/mem_top.sv
// Purpose: motion event manager with timers, compares, captures, encoder
// Assumes: AHB-Lite slave, zero wait states, all pins synchronous to hclk
// Notes: register bits 31:16 read zero
`timescale 1ns/100ps
`include "mem_defs.svh"
module mem_top #(
  parameter int AW = 8,
  parameter int DBW = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [1:0] external_timer_clock_pin,
  input wire logic count_direction_pin,
  input wire logic [2:0] capture_input_pin,
  input wire logic power_protect_input,
  input wire logic trip_soc_in,
  output logic trip_soc_out,
  output logic trip_soc_oe_n,
  output logic [5:0] pwm_out,
  output logic [5:0] pwm_oe_n,
  output logic [1:0] timer_pwm_out,
  output logic [1:0] timer_pwm_oe_n,
  output logic irq
);
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic wr_pend_reg;
  logic [5:0] wr_idx_reg;
  logic acc;
  logic rd_acc;
  logic [5:0] a_idx;
  logic [15:0] wd;
  logic [15:0] rdv;
  assign acc = hsel & htrans[1] & hready;
  assign rd_acc = acc & ~hwrite;
  assign a_idx = haddr[7:2];
  assign wd = hwdata[15:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 6'h00;
    end
    else
    begin
      wr_pend_reg <= acc & hwrite;
      if (acc)
        wr_idx_reg <= a_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (rd_acc)
      hrdata <= {16'h0, rdv};
  end

  function automatic logic wr_at(input logic [5:0] idx);
    return wr_pend_reg && (wr_idx_reg == idx);
  endfunction

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [15:0] gpt_reg, ext_reg, comcon_reg, act_sh_reg, act_reg, db_reg, capcon_reg;
  logic [11:0] mask_reg, flag_reg;
  logic load1;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gpt_reg <= `MEM_RST_WORD;
      ext_reg <= `MEM_RST_WORD;
      comcon_reg <= `MEM_RST_WORD;
      act_sh_reg <= `MEM_RST_WORD;
      db_reg <= `MEM_RST_WORD;
      capcon_reg <= `MEM_RST_WORD;
    end
    else
    begin
      if (wr_at(`MEM_R_GPT))
        gpt_reg <= wd;
      if (wr_at(`MEM_R_EXT))
        ext_reg <= {14'h0, wd[`MEM_F_TRIPEN:`MEM_F_SOCEN]};
      if (wr_at(`MEM_R_COMCON))
        comcon_reg <= wd;
      if (wr_at(`MEM_R_ACT))
        act_sh_reg <= wd;
      if (wr_at(`MEM_R_DB))
        db_reg <= wd;
      if (wr_at(`MEM_R_CAPCON))
        capcon_reg <= wd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      act_reg <= `MEM_RST_WORD;
    else if (load1)
      act_reg <= act_sh_reg;
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  logic [15:0] cnt_reg [2];
  logic [15:0] cmp_sh_reg [2];
  logic [15:0] cmp_reg [2];
  logic [15:0] per_sh_reg [2];
  logic [15:0] per_reg [2];
  logic [15:0] con_reg [2];
  logic [6:0] pre_reg [2];
  logic [1:0] xclk_reg;
  logic [1:0] up_reg;
  mem_pkg::mem_tcon_s tc [2];
  logic [1:0] run, sedge, pmatch, tick;
  logic [3:0] ev [2];
  logic enc_on, enc_up, enc_dn;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      tc[i] = mem_pkg::mem_tcon_s'(con_reg[i]);
      run[i] = tc[i].en;
      sedge[i] = tc[i].ext ? (external_timer_clock_pin[i] & ~xclk_reg[i]) : 1'b1;
      pmatch[i] = pre_reg[i] == 7'((8'h1 << tc[i].pre) - 8'h1);
      tick[i] = run[i] & sedge[i] & pmatch[i];
    end
    if (tc[1].sync)
    begin
      run[1] = run[0];
      tick[1] = tick[0];
    end
    for (int i = 0; i < 2; i++)
    begin
      // {overflow, underflow, compare, period}
      ev[i] = {4{tick[i] && tc[i].mode != mem_pkg::MEM_HOLD}} &
              {cnt_reg[i] == 16'hffff, cnt_reg[i] == 16'h0000,
               cnt_reg[i] == cmp_reg[i], cnt_reg[i] == per_reg[i]};
    end
  end
  assign load1 = !run[0] || (tick[0] && cnt_reg[0] == 16'h0000);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      xclk_reg <= 2'b00;
      for (int i = 0; i < 2; i++)
        pre_reg[i] <= 7'h0;
    end
    else
    begin
      xclk_reg <= external_timer_clock_pin;
      for (int i = 0; i < 2; i++)
        if (!run[i])
          pre_reg[i] <= 7'h0;
        else if (sedge[i])
          pre_reg[i] <= pmatch[i] ? 7'h0 : pre_reg[i] + 7'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      up_reg <= 2'b11;
      for (int i = 0; i < 2; i++)
      begin
        cnt_reg[i] <= `MEM_RST_WORD;
        cmp_sh_reg[i] <= `MEM_RST_WORD;
        cmp_reg[i] <= `MEM_RST_WORD;
        per_sh_reg[i] <= `MEM_RST_WORD;
        per_reg[i] <= `MEM_RST_WORD;
        con_reg[i] <= `MEM_RST_WORD;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_at(6'(`MEM_R_T1 + 6'(4 * i) + `MEM_O_CON)))
          con_reg[i] <= wd;
        if (wr_at(6'(`MEM_R_T1 + 6'(4 * i) + `MEM_O_CMP)))
          cmp_sh_reg[i] <= wd;
        if (wr_at(6'(`MEM_R_T1 + 6'(4 * i) + `MEM_O_PER)))
          per_sh_reg[i] <= wd;
        if (!run[i] || (tick[i] && cnt_reg[i] == 16'h0000))
        begin
          cmp_reg[i] <= cmp_sh_reg[i];
          per_reg[i] <= per_sh_reg[i];
        end
        if (wr_at(6'(`MEM_R_T1 + 6'(4 * i) + `MEM_O_CNT)))
          cnt_reg[i] <= wd;
        else if (i == 1 && enc_on)
        begin
          if (enc_up)
            cnt_reg[i] <= cnt_reg[i] + 16'h1;
          else if (enc_dn)
            cnt_reg[i] <= cnt_reg[i] - 16'h1;
        end
        else if (tick[i])
        begin
          unique case (tc[i].mode)
            mem_pkg::MEM_HOLD: ;
            mem_pkg::MEM_CONT_UP:
              cnt_reg[i] <= (cnt_reg[i] >= per_reg[i]) ? 16'h0 : cnt_reg[i] + 16'h1;
            mem_pkg::MEM_CONT_UPDN:
            begin
              if (up_reg[i] && cnt_reg[i] >= per_reg[i])
              begin
                up_reg[i] <= 1'b0;
                cnt_reg[i] <= cnt_reg[i] - 16'h1;
              end
              else if (!up_reg[i] && cnt_reg[i] == 16'h0)
              begin
                up_reg[i] <= 1'b1;
                cnt_reg[i] <= cnt_reg[i] + 16'h1;
              end
              else
                cnt_reg[i] <= up_reg[i] ? cnt_reg[i] + 16'h1 : cnt_reg[i] - 16'h1;
            end
            mem_pkg::MEM_DIR_UPDN:
            begin
              up_reg[i] <= count_direction_pin;
              if (count_direction_pin)
                cnt_reg[i] <= (cnt_reg[i] >= per_reg[i]) ? 16'h0 : cnt_reg[i] + 16'h1;
              else
                cnt_reg[i] <= (cnt_reg[i] == 16'h0) ? per_reg[i] : cnt_reg[i] - 16'h1;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // capture inputs, encoder
  // ----------------------------------------
  logic [2:0] cs1_reg, cs2_reg, cs3_reg, cq_reg;
  logic [1:0] qprev_reg;
  logic [2:0] chg, cap_ev;
  logic [1:0] qdiff;
  assign enc_on = capcon_reg[`MEM_F_ENC];
  assign chg = ~(cs2_reg ^ cs3_reg) & (cs2_reg ^ cq_reg);
  assign qdiff = {cq_reg[1], cq_reg[1] ^ cq_reg[0]} - {qprev_reg[1], qprev_reg[1] ^ qprev_reg[0]};
  assign enc_up = qdiff == `MEM_ENC_UP;
  assign enc_dn = qdiff == `MEM_ENC_DN;

  always_comb
  begin
    for (int i = 0; i < 3; i++)
      cap_ev[i] = capcon_reg[i] && !(enc_on && i < 2) &&
                  ((chg[i] && cs2_reg[i] && capcon_reg[`MEM_F_CEDGE + 2 * i]) ||
                   (chg[i] && !cs2_reg[i] && capcon_reg[`MEM_F_CEDGE + 2 * i + 1]));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cs1_reg <= 3'b000;
      cs2_reg <= 3'b000;
      cs3_reg <= 3'b000;
      cq_reg <= 3'b000;
      qprev_reg <= 2'b00;
    end
    else
    begin
      cs1_reg <= capture_input_pin;
      cs2_reg <= cs1_reg;
      cs3_reg <= cs2_reg;
      cq_reg <= cq_reg ^ chg;
      qprev_reg <= cq_reg[1:0];
    end
  end

  // ----------------------------------------
  // capture stacks
  // ----------------------------------------
  logic [15:0] top_reg [3];
  logic [15:0] bot_reg [3];
  logic [1:0] dep_reg [3];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        top_reg[i] <= `MEM_RST_WORD;
        bot_reg[i] <= `MEM_RST_WORD;
        dep_reg[i] <= 2'd0;
      end
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (rd_acc && a_idx == 6'(`MEM_R_CAPTOP + 6'(i)))
        begin
          if (cap_ev[i] && dep_reg[i] == 2'd2)
          begin
            top_reg[i] <= bot_reg[i];
            bot_reg[i] <= capcon_reg[`MEM_F_CTB + i] ? cnt_reg[0] : cnt_reg[1];
          end
          else if (cap_ev[i])
            top_reg[i] <= capcon_reg[`MEM_F_CTB + i] ? cnt_reg[0] : cnt_reg[1];
          else if (dep_reg[i] != 2'd0)
          begin
            top_reg[i] <= bot_reg[i];
            dep_reg[i] <= dep_reg[i] - 2'd1;
          end
        end
        else if (cap_ev[i])
        begin
          if (dep_reg[i] == 2'd0)
            top_reg[i] <= capcon_reg[`MEM_F_CTB + i] ? cnt_reg[0] : cnt_reg[1];
          else
          begin
            if (dep_reg[i] == 2'd2)
              top_reg[i] <= bot_reg[i];
            bot_reg[i] <= capcon_reg[`MEM_F_CTB + i] ? cnt_reg[0] : cnt_reg[1];
          end
          if (dep_reg[i] != 2'd2)
            dep_reg[i] <= dep_reg[i] + 2'd1;
        end
      end
    end
  end

  // ----------------------------------------
  // protect input, flags
  // ----------------------------------------
  logic ps1_reg, ps2_reg;
  logic hiz;
  logic [11:0] fset, fclr;
  assign hiz = !ps2_reg && mask_reg[0];
  assign fset = {cap_ev, ev[1], ev[0], !ps2_reg};
  assign fclr = {{3{wr_at(`MEM_R_IFRC)}} & wd[2:0], {4{wr_at(`MEM_R_IFRB)}} & wd[3:0],
                 {5{wr_at(`MEM_R_IFRA)}} & wd[4:0]};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ps1_reg <= 1'b1;
      ps2_reg <= 1'b1;
      mask_reg <= 12'(`MEM_RST_IMRA);
      flag_reg <= 12'h000;
      irq <= 1'b0;
    end
    else
    begin
      ps1_reg <= power_protect_input;
      ps2_reg <= ps1_reg;
      if (wr_at(`MEM_R_IMRA))
        mask_reg[4:0] <= wd[4:0];
      if (wr_at(`MEM_R_IMRB))
        mask_reg[8:5] <= wd[3:0];
      if (wr_at(`MEM_R_IMRC))
        mask_reg[11:9] <= wd[2:0];
      flag_reg <= (flag_reg & ~fclr) | fset;
      irq <= |(flag_reg & mask_reg);
    end
  end

  // ----------------------------------------
  // compare units, deadband, outputs
  // ----------------------------------------
  logic [15:0] ucmp_sh_reg [3];
  logic [15:0] ucmp_reg [3];
  logic [DBW-1:0] dbc_reg [3];
  logic [2:0] rawd_reg, raw, hi, lo, va, vb;
  logic [5:0] lvl, pin;
  assign va = act_reg[14:12];
  assign vb = act_reg[`MEM_F_SVDIR] ? {va[1:0], va[2]} : {va[0], va[2:1]};

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (comcon_reg[`MEM_F_SVM])
        raw[i] = (cnt_reg[0] < ucmp_reg[0]) ? va[i] : ((cnt_reg[0] < ucmp_reg[1]) ? vb[i] : 1'b0);
      else
        raw[i] = cnt_reg[0] < ucmp_reg[i];
      hi[i] = rawd_reg[i] && (dbc_reg[i] == '0);
      lo[i] = !rawd_reg[i] && (dbc_reg[i] == '0);
      lvl[2 * i] = hi[i];
      lvl[2 * i + 1] = lo[i];
    end
    for (int k = 0; k < 6; k++)
      pin[k] = act_reg[2 * k + 1] ? (act_reg[2 * k] | lvl[k]) : (act_reg[2 * k] & ~lvl[k]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rawd_reg <= 3'b000;
      for (int i = 0; i < 3; i++)
      begin
        ucmp_sh_reg[i] <= `MEM_RST_WORD;
        ucmp_reg[i] <= `MEM_RST_WORD;
        dbc_reg[i] <= '0;
      end
    end
    else
    begin
      rawd_reg <= raw;
      for (int i = 0; i < 3; i++)
      begin
        if (wr_at(6'(`MEM_R_CMP1 + 6'(i))))
          ucmp_sh_reg[i] <= wd;
        if (load1)
          ucmp_reg[i] <= ucmp_sh_reg[i];
        if (raw[i] != rawd_reg[i] && db_reg[`MEM_F_DBEN + i])
          dbc_reg[i] <= db_reg[`MEM_F_DBV +: DBW];
        else if (dbc_reg[i] != '0)
          dbc_reg[i] <= dbc_reg[i] - 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwm_out <= 6'h00;
      pwm_oe_n <= 6'h3f;
      timer_pwm_out <= 2'b00;
      timer_pwm_oe_n <= 2'b11;
      trip_soc_out <= 1'b0;
      trip_soc_oe_n <= 1'b1;
    end
    else
    begin
      pwm_out <= pin;
      pwm_oe_n <= {6{!comcon_reg[`MEM_F_CEN] || hiz}};
      for (int i = 0; i < 2; i++)
      begin
        timer_pwm_out[i] <= tc[i].pol ~^ (cnt_reg[i] >= cmp_reg[i]);
        timer_pwm_oe_n[i] <= !tc[i].oe || hiz ||
                             (ext_reg[`MEM_F_TRIPEN] && !ext_reg[`MEM_F_SOCEN] && !trip_soc_in);
      end
      trip_soc_oe_n <= !ext_reg[`MEM_F_SOCEN];
      unique case (gpt_reg[1:0])
        `MEM_SOC_UND: trip_soc_out <= ev[0][2];
        `MEM_SOC_PER: trip_soc_out <= ev[0][0];
        `MEM_SOC_CMP: trip_soc_out <= ev[0][1];
        default: trip_soc_out <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb
  begin
    rdv = 16'h0;
    case (a_idx)
      `MEM_R_GPT: rdv = gpt_reg;
      `MEM_R_EXT: rdv = ext_reg;
      `MEM_R_COMCON: rdv = {comcon_reg[15:9], ps2_reg, comcon_reg[7:0]};
      `MEM_R_ACT: rdv = act_sh_reg;
      `MEM_R_DB: rdv = db_reg;
      `MEM_R_CAPCON: rdv = capcon_reg;
      `MEM_R_CAPST: rdv = {10'h0, dep_reg[2], dep_reg[1], dep_reg[0]};
      `MEM_R_IMRA: rdv = {11'h0, mask_reg[4:0]};
      `MEM_R_IMRB: rdv = {12'h0, mask_reg[8:5]};
      `MEM_R_IMRC: rdv = {13'h0, mask_reg[11:9]};
      `MEM_R_IFRA: rdv = {11'h0, flag_reg[4:0]};
      `MEM_R_IFRB: rdv = {12'h0, flag_reg[8:5]};
      `MEM_R_IFRC: rdv = {13'h0, flag_reg[11:9]};
      default:
      begin
        for (int i = 0; i < 2; i++)
        begin
          if (a_idx == 6'(`MEM_R_T1 + 6'(4 * i) + `MEM_O_CNT))
            rdv = cnt_reg[i];
          if (a_idx == 6'(`MEM_R_T1 + 6'(4 * i) + `MEM_O_CMP))
            rdv = cmp_sh_reg[i];
          if (a_idx == 6'(`MEM_R_T1 + 6'(4 * i) + `MEM_O_PER))
            rdv = per_sh_reg[i];
          if (a_idx == 6'(`MEM_R_T1 + 6'(4 * i) + `MEM_O_CON))
            rdv = con_reg[i];
        end
        for (int i = 0; i < 3; i++)
        begin
          if (a_idx == 6'(`MEM_R_CMP1 + 6'(i)))
            rdv = ucmp_sh_reg[i];
          if (a_idx == 6'(`MEM_R_CAPTOP + 6'(i)))
            rdv = top_reg[i];
          if (a_idx == 6'(`MEM_R_CAPBOT + 6'(i)))
            rdv = bot_reg[i];
        end
      end
    endcase
  end
endmodule

// ### bench/mem_bridge_model.sv
// Purpose: far-side model of encoder, capture, protect and shared trip pins
// Assumes: the bench calls its tasks, which change pins just after a rising edge
// Notes: shared trip pin has a pull-up while the block releases it
`timescale 1ns/100ps
module mem_bridge_model (
  input wire logic hclk,
  input wire logic trip_soc_out,
  input wire logic trip_soc_oe_n,
  output logic [2:0] capture_input_pin,
  output logic power_protect_input,
  output logic trip_soc_in
);
  logic [1:0] phase = 2'b00;
  initial capture_input_pin = 3'h0;
  initial power_protect_input = 1'b1;
  // block drives the shared pin while its enable is low
  assign trip_soc_in = !trip_soc_oe_n ? trip_soc_out : 1'b1;
  // one gray step; phase a leads when counting up
  task automatic enc_step(input logic up);
    logic [1:0] nxt;
    nxt = up ? {phase[0], ~phase[1]} : {~phase[0], phase[1]};
    @(posedge hclk);
    capture_input_pin[1:0] <= nxt;
    phase <= nxt;
    repeat (4) @(posedge hclk);
  endtask
  task automatic cap_level(input int ch, input logic lvl, input int hold);
    @(posedge hclk);
    capture_input_pin[ch] <= lvl;
    repeat (hold) @(posedge hclk);
  endtask
  task automatic protect(input logic lvl, input int hold);
    @(posedge hclk);
    power_protect_input <= lvl;
    repeat (hold) @(posedge hclk);
  endtask
endmodule

// ### bench/mem_top_props.sv
// Purpose: bus and pin checks for mem_top
// Assumes: bound to mem_top
// Notes: tracks protect mask and trigger enable from bus writes
`timescale 1ns/100ps
module mem_top_props #(
  parameter int AW = 8,
  parameter int DBW = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic power_protect_input,
  input wire logic trip_soc_out,
  input wire logic trip_soc_oe_n,
  input wire logic [5:0] pwm_oe_n,
  input wire logic irq
);
  localparam logic [63:0] MAPPED = 64'h0003f3bd_03aa03ff;
  logic wr_reg;
  logic [5:0] idx_reg;
  logic mask_reg;
  logic soc_reg;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_reg <= 1'b0;
      idx_reg <= 6'h00;
    end
    else if (hready)
    begin
      wr_reg <= hsel && htrans[1] && hwrite;
      idx_reg <= haddr[7:2];
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_reg <= 1'b1;
      soc_reg <= 1'b0;
    end
    else if (wr_reg && hready && idx_reg == 6'h2c)
      mask_reg <= hwdata[0];
    else if (wr_reg && hready && idx_reg == 6'h09)
      soc_reg <= hwdata[0];
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_read;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_prot;
    (!power_protect_input && mask_reg)[*3];
  endsequence
  AST_READY: assert property (hreadyout) else $error("wait state seen");
  AST_OKAY: assert property (!hresp) else $error("error response seen");
  AST_UPPER: assert property (s_read |=> hrdata[31:16] == 16'h0000) else $error("upper bits set");
  AST_HOLE: assert property (s_read ##0 !MAPPED[haddr[7:2]] |=> hrdata == 32'h0) else $error("hole read");
  AST_FLOAT: assert property (s_prot |=> pwm_oe_n == 6'h3f) else $error("pwm pins driven");
  AST_FLAG: assert property (s_prot |-> ##[1:2] irq) else $error("protect irq missing");
  AST_PULSE: assert property (trip_soc_out |=> !trip_soc_out) else $error("trigger too long");
  AST_SOC_OFF: assert property (!trip_soc_oe_n |-> soc_reg || $past(soc_reg)) else $error("pin driven");
  AST_SOC_ON: assert property (soc_reg [*2] |-> !trip_soc_oe_n) else $error("pin not driven");
endmodule
bind mem_top mem_top_props #(.AW(AW), .DBW(DBW)) i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .power_protect_input(power_protect_input), .trip_soc_out(trip_soc_out),
  .trip_soc_oe_n(trip_soc_oe_n), .pwm_oe_n(pwm_oe_n), .irq(irq));

// ### bench/testbench.sv
// Purpose: self-checking bench for mem_top
// Assumes: zero-wait AHB-Lite slave, byte address is four times the index
// Notes: random data from a fixed-seed xorshift
`timescale 1ns/100ps
`include "mem_defs.svh"
module testbench;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic dir_pin;
  logic [1:0] xclk = 2'b00;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [2:0] cap_pins;
  logic prot_n;
  logic trip_in;
  logic soc_out;
  logic soc_oe_n;
  logic [5:0] pwm;
  logic [5:0] pwm_oe_n;
  logic [1:0] tpwm;
  logic [1:0] tpwm_oe_n;
  logic irq;
  logic [31:0] seed = 32'h2ac7be36;
  logic [31:0] rd;
  int error_cnt = 0;
  int checks = 0;
  int n;
  logic [5:0] regs [9] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h17, 6'h18, 6'h19};
  logic [5:0] holes [4] = '{6'h0a, 6'h10, 6'h2b, 6'h3f};
  mem_top #(.AW(8), .DBW(4)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .external_timer_clock_pin(xclk), .count_direction_pin(dir_pin),
    .capture_input_pin(cap_pins), .power_protect_input(prot_n), .trip_soc_in(trip_in), .trip_soc_out(soc_out),
    .trip_soc_oe_n(soc_oe_n), .pwm_out(pwm), .pwm_oe_n(pwm_oe_n), .timer_pwm_out(tpwm),
    .timer_pwm_oe_n(tpwm_oe_n), .irq(irq));
  mem_bridge_model i_model (.hclk(hclk), .trip_soc_out(soc_out), .trip_soc_oe_n(soc_oe_n),
    .capture_input_pin(cap_pins), .power_protect_input(prot_n), .trip_soc_in(trip_in));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] depth(input int e);
    return 32'(e[0]) + 32'(e[1]);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wrap_up;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial
  begin
    #3000000;
    error_cnt++;
    wrap_up();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    dir_pin = 1'b1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(`MEM_R_IMRA, 32'h1);
    rchk(`MEM_R_EXT, 32'h0);
    rchk(`MEM_R_COMCON, 32'h100);
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      bus(1'b1, regs[seed[19:16] % 9], seed);
      rchk(regs[seed[19:16] % 9], {16'h0, seed[15:0]});
    end
    foreach (holes[i])
    begin
      bus(1'b1, holes[i], 32'hffffffff);
      rchk(holes[i], 32'h0);
    end
    bus(1'b1, `MEM_R_EXT, 32'hffffffff);
    rchk(`MEM_R_EXT, 32'h3);
    bus(1'b1, `MEM_R_EXT, 32'h0);
    bus(1'b1, `MEM_R_COMCON, 32'h8000);
    i_model.protect(1'b0, 5);
    chk(32'(pwm_oe_n), 32'h3f);
    chk(32'(irq), 32'h1);
    rchk(`MEM_R_COMCON, 32'h8000);
    bus(1'b1, `MEM_R_IMRA, 32'h0);
    i_model.protect(1'b1, 4);
    bus(1'b1, `MEM_R_IFRA, 32'h1);
    rchk(`MEM_R_IFRA, 32'h0);
    i_model.protect(1'b0, 4);
    rchk(`MEM_R_IFRA, 32'h1);
    i_model.protect(1'b1, 4);
    bus(1'b1, `MEM_R_IFRA, 32'h1);
    seed = xs(seed);
    bus(1'b1, `MEM_R_T1, seed);
    for (int e = 1; e < 4; e++)
    begin
      bus(1'b1, `MEM_R_CAPCON, 32'h9 | 32'(e << 6));
      i_model.cap_level(0, 1'b1, 0);
      i_model.cap_level(0, 1'b0, 4);
      rchk(`MEM_R_CAPST, 32'h0);
      i_model.cap_level(0, 1'b1, 4);
      i_model.cap_level(0, 1'b0, 4);
      rchk(`MEM_R_CAPST, depth(e));
      rchk(`MEM_R_IFRC, 32'h1);
      repeat (depth(e)) rchk(`MEM_R_CAPTOP, {16'h0, seed[15:0]});
      rchk(`MEM_R_CAPST, 32'h0);
      bus(1'b1, `MEM_R_IFRC, 32'h7);
    end
    seed = xs(seed);
    bus(1'b1, `MEM_R_CAPCON, 32'h1000);
    bus(1'b1, `MEM_R_T2, seed);
    repeat (8) i_model.enc_step(1'b1);
    repeat (3) i_model.enc_step(1'b0);
    rchk(`MEM_R_T2, {16'h0, seed[15:0] + 16'h5});
    bus(1'b1, `MEM_R_CAPCON, 32'h0);
    bus(1'b1, 6'h07, 32'hffff);
    bus(1'b1, `MEM_R_T2, 32'h0);
    bus(1'b1, 6'h08, 32'h63);
    for (int i = 0; i < 14; i++)
    begin
      @(posedge hclk);
      xclk <= ~xclk;
      dir_pin <= i < 10;
    end
    rchk(`MEM_R_T2, 32'h3);
    bus(1'b1, `MEM_R_GPT, {30'h0, `MEM_SOC_PER});
    bus(1'b1, `MEM_R_EXT, 32'h1);
    bus(1'b1, 6'h03, 32'h10);
    bus(1'b1, 6'h04, 32'h41);
    n = 0;
    while (soc_out !== 1'b1 && n < 200)
    begin
      @(posedge hclk);
      n++;
    end
    chk(32'(n < 200), 32'h1);
    chk(32'(soc_oe_n), 32'h0);
    wrap_up();
  end
endmodule
